// >>> dsb_regs.svh
// Register indices, field positions, reset values and codes of the sideband bank
`ifndef DSB_REGS_SVH
`define DSB_REGS_SVH
`define DSB_IDX_INPROG    8'h31
`define DSB_IDX_SELECT    8'h37
`define DSB_IDX_OPERAND   8'h38
`define DSB_IDX_CHIPID    8'h39
`define DSB_IDX_CALSTS    8'h3B
`define DSB_IDX_IFWIDTH   8'h44
`define DSB_IDX_TOOLVER   8'h45
`define DSB_IDX_REFACK    8'h4F
`define DSB_IDX_LAUNCH    8'h60
`define DSB_IDX_IRQSTS    8'h61
`define DSB_IDX_IRQEN     8'h62
`define DSB_IDX_IRQCLR    8'h63
`define DSB_KIND_HI       2
`define DSB_KIND_LO       0
`define DSB_RANK_HI       6
`define DSB_RANK_LO       3
`define DSB_CHIPID_HI     3
`define DSB_CHIPID_LO     1
`define DSB_OP_CID_HI     26
`define DSB_OP_CID_LO     24
`define DSB_OP_ACT        23
`define DSB_OP_BG_HI      22
`define DSB_OP_BG_LO      21
`define DSB_OP_BA3_HI     20
`define DSB_OP_BA_HI      19
`define DSB_OP_BA_LO      18
`define DSB_OP_AHI        17
`define DSB_OP_RCW_HI     16
`define DSB_OP_RCW_LO     14
`define DSB_OP_A_HI       13
`define DSB_OP_A_LO       0
`define DSB_SELECT_RST    7'h00
`define DSB_OPERAND_RST   32'h0000_0000
`define DSB_IRQ_RST       4'h0
`define DSB_KIND_MODE_REGISTER_SET 3'h0
`define DSB_RESP_OKAY     2'h0
`define DSB_RESP_SLVERR   2'h2
`endif

// >>> dsb_pkg.sv
// Shared types of the sideband command register bank
package dsb_pkg;
  typedef logic [31:0] dsb_word_t;
  typedef logic [7:0]  dsb_idx_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ISSUE, SEQ_WAIT} dsb_seq_state_t;
endpackage

// >>> dsb_axil_slave.sv
// AXI4-Lite slave front end, one write and one read in flight
`timescale 1ns/1ns
`default_nettype none
`include "dsb_regs.svh"
module dsb_axil_slave
  import dsb_pkg::*;
#(
  parameter int AW = 12
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [AW-1:0] awaddr,
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic          wvalid,
  output logic               wready,
  output logic [1:0]         bresp,
  output logic               bvalid,
  input  wire logic          bready,
  input  wire logic [AW-1:0] araddr,
  input  wire logic          arvalid,
  output logic               arready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  output logic               rvalid,
  input  wire logic          rready,
  output logic               wr_req,
  output dsb_idx_t           wr_idx,
  output dsb_word_t          wr_data,
  output logic [3:0]         wr_strb,
  input  wire logic          wr_ok,
  output logic               rd_req,
  output dsb_idx_t           rd_idx,
  input  wire dsb_word_t     rd_data,
  input  wire logic          rd_ok
);
  logic      aw_rdy_q, w_rdy_q, ar_rdy_q, bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  dsb_idx_t  awidx_q, aridx_q;
  dsb_word_t wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  // Ready drops on acceptance, so each side holds one item until the answer is taken
  assign wr_req  = !aw_rdy_q && !w_rdy_q && !bvalid_q;
  assign rd_req  = !ar_rdy_q && !rvalid_q;
  assign wr_idx  = awidx_q;
  assign wr_data = wdata_q;
  assign wr_strb = wstrb_q;
  assign rd_idx  = aridx_q;
  assign awready = aw_rdy_q;
  assign wready  = w_rdy_q;
  assign arready = ar_rdy_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign rvalid  = rvalid_q;
  assign rresp   = rresp_q;
  assign rdata   = rdata_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_rdy_q <= 1'b1;
      w_rdy_q  <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q  <= `DSB_RESP_OKAY;
      awidx_q  <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else begin
      if (awvalid && aw_rdy_q) begin
        aw_rdy_q <= 1'b0;
        awidx_q  <= awaddr[9:2];
      end
      if (wvalid && w_rdy_q) begin
        w_rdy_q <= 1'b0;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_req) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_ok ? `DSB_RESP_OKAY : `DSB_RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
        aw_rdy_q <= 1'b1;
        w_rdy_q  <= 1'b1;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_rdy_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q  <= `DSB_RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
      aridx_q  <= 8'h00;
    end else if (arvalid && ar_rdy_q) begin
      ar_rdy_q <= 1'b0;
      aridx_q  <= araddr[9:2];
    end else if (rd_req) begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_ok ? `DSB_RESP_OKAY : `DSB_RESP_SLVERR;
      rdata_q  <= rd_ok ? rd_data : 32'h0000_0000;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
      ar_rdy_q <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> dsb_cmd_seq.sv
// Mode register command sequencer: launch, hand to scheduler, wait for completion
`timescale 1ns/1ns
`default_nettype none
`include "dsb_regs.svh"
module dsb_cmd_seq
  import dsb_pkg::*;
#(
  parameter int PW = 27
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          launch,
  input  wire logic [2:0]    kind,
  input  wire logic [3:0]    rank,
  input  wire logic [PW-1:0] payload,
  input  wire logic          cmd_ready,
  input  wire logic          cmd_done,
  output logic               cmd_valid,
  output logic [3:0]         cmd_cs,
  output logic [PW-1:0]      cmd_payload,
  output logic               busy,
  output logic               done,
  output logic               reject
);
  dsb_seq_state_t state_q, state_d;
  logic          valid_q, busy_q, done_q, reject_q, accept;
  logic [3:0]    cs_q;
  logic [PW-1:0] pl_q;
  assign accept = launch && state_q == SEQ_IDLE && kind == `DSB_KIND_MODE_REGISTER_SET && rank != 4'h0;
  always_comb begin
    state_d = state_q;
    case (state_q)
      SEQ_IDLE:  if (accept) state_d = SEQ_ISSUE;
      SEQ_ISSUE: if (cmd_ready) state_d = SEQ_WAIT;
      SEQ_WAIT:  if (cmd_done) state_d = SEQ_IDLE;
      default:   state_d = SEQ_IDLE;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q  <= SEQ_IDLE;
      valid_q  <= 1'b0;
      busy_q   <= 1'b0;
      done_q   <= 1'b0;
      reject_q <= 1'b0;
      cs_q     <= 4'h0;
      pl_q     <= '0;
    end else begin
      state_q  <= state_d;
      valid_q  <= state_d == SEQ_ISSUE;
      busy_q   <= state_d != SEQ_IDLE;
      done_q   <= state_q == SEQ_WAIT && cmd_done;
      reject_q <= launch && !accept;
      if (accept) begin
        cs_q <= rank;
        pl_q <= payload;
      end
    end
  end
  assign cmd_valid   = valid_q;
  assign cmd_cs      = cs_q;
  assign cmd_payload = pl_q;
  assign busy        = busy_q;
  assign done        = done_q;
  assign reject      = reject_q;
endmodule
`default_nettype wire

// >>> dsb_sideband_regs.sv
// Sideband mode register command and status register bank, top level
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "dsb_regs.svh"
// What this block does
// - Command kind 000 is mode register set.
// - Rank field bits select chip selects.
// - Any nonzero chip select mix gets the command.
// - DDR4 operand carries chip, bank group, bank.
// - DDR3 operand carries three bank bits, A14.
// - Report 3DS refresh chip ID, bits 3:1.
// - Status bit 0 shows calibration success.
// - Status bit 1 shows calibration failure.
// - Refresh acknowledge word, one byte per rank.
// - In-progress flag high while command runs.
module dsb_sideband_regs
  import dsb_pkg::*;
#(
  parameter logic [15:0] IF_WIDTH_VALUE     = 16'h0020,
  parameter logic [15:0] TOOL_VERSION_VALUE = 16'h0001
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        ddr4_mode,
  input  wire logic        phy_cal_success,
  input  wire logic        phy_cal_fail,
  input  wire logic [2:0]  refresh_chip_id,
  input  wire logic [31:0] stacked_refresh_acknowledge_in,
  input  wire logic        cmd_ready,
  input  wire logic        cmd_done,
  output logic             cmd_valid,
  output logic [3:0]       cmd_cs,
  output logic [2:0]       cmd_chip_id,
  output logic             cmd_act,
  output logic [1:0]       cmd_bank_group,
  output logic [2:0]       cmd_bank,
  output logic             cmd_addr_hi,
  output logic             cmd_ras_n,
  output logic             cmd_cas_n,
  output logic             cmd_we_n,
  output logic [13:0]      cmd_addr,
  output logic             irq
);
  localparam int PW = 27;

  function automatic dsb_word_t merge_strb(dsb_word_t old, dsb_word_t nw, logic [3:0] strb);
    dsb_word_t r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  function automatic logic idx_mapped(dsb_idx_t idx);
    return idx == `DSB_IDX_INPROG || idx == `DSB_IDX_SELECT || idx == `DSB_IDX_OPERAND ||
           idx == `DSB_IDX_CHIPID || idx == `DSB_IDX_CALSTS || idx == `DSB_IDX_IFWIDTH ||
           idx == `DSB_IDX_TOOLVER || idx == `DSB_IDX_REFACK || idx == `DSB_IDX_LAUNCH ||
           idx == `DSB_IDX_IRQSTS || idx == `DSB_IDX_IRQEN || idx == `DSB_IDX_IRQCLR;
  endfunction

  logic       wr_req, rd_req, wr_ok, rd_ok;
  dsb_idx_t   wr_idx, rd_idx;
  dsb_word_t  wr_data, rd_data;
  logic [3:0] wr_strb;

  dsb_axil_slave #(
    .AW (12)
  ) dsb_axil_slave_i (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr_req  (wr_req),
    .wr_idx  (wr_idx),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_ok),
    .rd_req  (rd_req),
    .rd_idx  (rd_idx),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  logic [6:0]  sel_q, sel_d;
  dsb_word_t   operand_q, operand_d;
  logic [3:0]  irq_en_q, irq_en_d, irq_sts_q, irq_sts_d;
  logic        irq_q;
  logic [1:0]  cal_q;
  logic [2:0]  chip_id_q;
  dsb_word_t   ack_q;

  logic        wr_sel, wr_op, wr_en, wr_clr, launch;
  dsb_word_t   sel_m, op_m, en_m;
  logic [3:0]  irq_clr, irq_ev;
  logic [2:0]  command_kind;
  logic [3:0]  command_target_rank;

  assign wr_ok  = idx_mapped(wr_idx);
  assign rd_ok  = idx_mapped(rd_idx);
  assign wr_sel = wr_req && wr_idx == `DSB_IDX_SELECT;
  assign wr_op  = wr_req && wr_idx == `DSB_IDX_OPERAND;
  assign wr_en  = wr_req && wr_idx == `DSB_IDX_IRQEN;
  assign wr_clr = wr_req && wr_idx == `DSB_IDX_IRQCLR && wr_strb[0];
  // Launch is a separate write so that select and operand can be set in any order first
  assign launch = wr_req && wr_idx == `DSB_IDX_LAUNCH && wr_strb[0] && wr_data[0];

  assign sel_m     = merge_strb({25'h0, sel_q}, wr_data, wr_strb);
  assign op_m      = merge_strb(operand_q, wr_data, wr_strb);
  assign en_m      = merge_strb({28'h0, irq_en_q}, wr_data, wr_strb);
  assign sel_d     = wr_sel ? sel_m[6:0] : sel_q;
  assign operand_d = wr_op ? op_m : operand_q;
  assign irq_en_d  = wr_en ? en_m[3:0] : irq_en_q;

  assign command_kind        = sel_q[`DSB_KIND_HI:`DSB_KIND_LO];
  assign command_target_rank = sel_q[`DSB_RANK_HI:`DSB_RANK_LO];

  // Operand decode; DDR3 has no bank group or chip ID, so those read as zero
  logic [2:0]    op_cid, op_bank;
  logic          op_act;
  logic [1:0]    op_bg;
  logic [PW-1:0] payload, cmd_payload;
  assign op_cid  = ddr4_mode ? operand_q[`DSB_OP_CID_HI:`DSB_OP_CID_LO] : 3'h0;
  assign op_act  = ddr4_mode & operand_q[`DSB_OP_ACT];
  assign op_bg   = ddr4_mode ? operand_q[`DSB_OP_BG_HI:`DSB_OP_BG_LO] : 2'h0;
  assign op_bank = ddr4_mode ? {1'b0, operand_q[`DSB_OP_BA_HI:`DSB_OP_BA_LO]}
                             : operand_q[`DSB_OP_BA3_HI:`DSB_OP_BA_LO];
  assign payload = {op_cid, op_act, op_bg, op_bank, operand_q[`DSB_OP_AHI],
                    operand_q[`DSB_OP_RCW_HI:`DSB_OP_RCW_LO],
                    operand_q[`DSB_OP_A_HI:`DSB_OP_A_LO]};

  logic cmd_busy, cmd_fin, cmd_rej;

  dsb_cmd_seq #(
    .PW (PW)
  ) dsb_cmd_seq_i (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .launch      (launch),
    .kind        (command_kind),
    .rank        (command_target_rank),
    .payload     (payload),
    .cmd_ready   (cmd_ready),
    .cmd_done    (cmd_done),
    .cmd_valid   (cmd_valid),
    .cmd_cs      (cmd_cs),
    .cmd_payload (cmd_payload),
    .busy        (cmd_busy),
    .done        (cmd_fin),
    .reject      (cmd_rej)
  );

  assign cmd_addr    = cmd_payload[13:0];
  assign cmd_we_n    = cmd_payload[14];
  assign cmd_cas_n   = cmd_payload[15];
  assign cmd_ras_n   = cmd_payload[16];
  assign cmd_addr_hi = cmd_payload[17];
  assign cmd_bank    = cmd_payload[20:18];
  assign cmd_bank_group = cmd_payload[22:21];
  assign cmd_act     = cmd_payload[23];
  assign cmd_chip_id = cmd_payload[26:24];

  // Calibration events fire on the rising level; a level that stays high raises one event
  assign irq_ev    = {cmd_rej, cmd_fin, phy_cal_fail & ~cal_q[1], phy_cal_success & ~cal_q[0]};
  assign irq_clr   = wr_clr ? wr_data[3:0] : 4'h0;
  assign irq_sts_d = (irq_sts_q & ~irq_clr) | irq_ev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_q     <= `DSB_SELECT_RST;
      operand_q <= `DSB_OPERAND_RST;
      irq_en_q  <= `DSB_IRQ_RST;
      irq_sts_q <= `DSB_IRQ_RST;
      irq_q     <= 1'b0;
    end else begin
      sel_q     <= sel_d;
      operand_q <= operand_d;
      irq_en_q  <= irq_en_d;
      irq_sts_q <= irq_sts_d;
      irq_q     <= |(irq_sts_d & irq_en_d);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_q     <= 2'h0;
      chip_id_q <= 3'h0;
      ack_q     <= 32'h0000_0000;
    end else begin
      cal_q     <= {phy_cal_fail, phy_cal_success};
      chip_id_q <= refresh_chip_id;
      ack_q     <= stacked_refresh_acknowledge_in;
    end
  end

  assign irq = irq_q;

  assign rd_data =
    (rd_idx == `DSB_IDX_INPROG)  ? {31'h0, cmd_busy} :
    (rd_idx == `DSB_IDX_SELECT)  ? {25'h0, sel_q} :
    (rd_idx == `DSB_IDX_OPERAND) ? operand_q :
    (rd_idx == `DSB_IDX_CHIPID)  ? {28'h0, chip_id_q, 1'b0} :
    (rd_idx == `DSB_IDX_CALSTS)  ? {30'h0, cal_q} :
    (rd_idx == `DSB_IDX_IFWIDTH) ? {16'h0, IF_WIDTH_VALUE} :
    (rd_idx == `DSB_IDX_TOOLVER) ? {16'h0, TOOL_VERSION_VALUE} :
    (rd_idx == `DSB_IDX_REFACK)  ? ack_q :
    (rd_idx == `DSB_IDX_IRQSTS)  ? {28'h0, irq_sts_q} :
    (rd_idx == `DSB_IDX_IRQEN)   ? {28'h0, irq_en_q} :
    32'h0000_0000;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_launch_ok;
    launch && !cmd_busy && command_kind == `DSB_KIND_MODE_REGISTER_SET && command_target_rank != 4'h0;
  endsequence

  sequence s_handoff;
    cmd_valid && cmd_ready;
  endsequence

  a_kind_reserved: assert property (
    launch && command_kind != `DSB_KIND_MODE_REGISTER_SET && !cmd_busy |=> !cmd_valid && !cmd_busy)
    else $error("reserved command kind was issued");

  a_rank_mask: assert property (
    s_launch_ok |=> cmd_valid && cmd_cs == $past(command_target_rank))
    else $error("chip select mask differs from rank field");

  a_rank_hold: assert property (
    cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_cs) && $stable(cmd_addr))
    else $error("command dropped before scheduler took it");

  a_ddr4_layout: assert property (
    s_launch_ok ##0 ddr4_mode |=> cmd_bank_group == $past(operand_q[22:21]) &&
      cmd_bank == {1'b0, $past(operand_q[19:18])} && cmd_chip_id == $past(operand_q[26:24]))
    else $error("DDR4 operand fields misplaced");

  a_ddr3_layout: assert property (
    s_launch_ok ##0 !ddr4_mode |=> cmd_bank == $past(operand_q[20:18]) && cmd_bank_group == 2'h0 &&
      cmd_addr_hi == $past(operand_q[17]) && cmd_addr == $past(operand_q[13:0]))
    else $error("DDR3 operand fields misplaced");

  a_chip_id_read: assert property (
    rd_req && rd_idx == `DSB_IDX_CHIPID |-> rd_data[3:1] == $past(refresh_chip_id) && rd_data[0] == 1'b0)
    else $error("chip ID read back wrong");

  a_cal_success: assert property (
    phy_cal_success && !cal_q[0] |=> cal_q[0] && irq_sts_q[0])
    else $error("calibration success not reported");

  a_cal_fail: assert property (
    phy_cal_fail && !cal_q[1] |=> cal_q[1] && irq_sts_q[1])
    else $error("calibration failure not reported");

  a_ack_read: assert property (
    rd_req && rd_idx == `DSB_IDX_REFACK |-> rd_data == $past(stacked_refresh_acknowledge_in))
    else $error("refresh acknowledge word read back wrong");

  a_busy_span: assert property (
    s_launch_ok |=> cmd_busy [*2])
    else $error("in-progress flag not held for the command");

  a_busy_end: assert property (
    $fell(cmd_busy) |-> $past(cmd_done) && $past(!cmd_valid))
    else $error("in-progress flag fell without completion");

  a_handoff: assert property (
    s_handoff |=> !cmd_valid && cmd_busy)
    else $error("command not retired after hand-off");

  a_sel_hold: assert property (
    !wr_sel && !wr_op |=> $stable(sel_q) && $stable(operand_q))
    else $error("command fields changed without a write");

  a_info_read: assert property (
    rd_req && rd_idx == `DSB_IDX_TOOLVER |-> rd_data == {16'h0, TOOL_VERSION_VALUE} && rd_ok)
    else $error("tool version word read back wrong");

  a_irq_level: assert property (
    (irq_sts_q & irq_en_q) != 4'h0 && !wr_clr && !wr_en |=> irq)
    else $error("interrupt low with enabled status set");

  a_kind_refused: assert property (
    launch && command_kind != `DSB_KIND_MODE_REGISTER_SET |=> cmd_rej)
    else $error("reserved command kind not refused");

  a_cs_nonzero: assert property (
    cmd_valid |-> cmd_cs != 4'h0)
    else $error("command issued with no chip select");

  a_cs_hold: assert property (
    cmd_busy |=> $stable(cmd_cs) && $stable(cmd_addr))
    else $error("chip select changed during a command");

  a_busy_start: assert property (
    $rose(cmd_busy) |-> $past(launch) && $past(command_target_rank) != 4'h0)
    else $error("in-progress flag rose without a launch");

  // A new event outranks a clear that lands in the same cycle
  a_event_sticky: assert property (
    irq_ev != 4'h0 |=> (irq_sts_q & $past(irq_ev)) == $past(irq_ev))
    else $error("event lost against a clear in the same cycle");

  a_irq_clear: assert property (
    wr_clr && (irq_sts_q & ~wr_data[3:0]) == 4'h0 && irq_ev == 4'h0 |=> irq_sts_q == 4'h0 && !irq)
    else $error("status or interrupt survived a full clear");

endmodule
`default_nettype wire

// >>> dsb_sideband_regs_test.sv
// Self-checking bench for the sideband command and status register bank
`timescale 1ns/1ns
`default_nettype none
`include "dsb_regs.svh"
module dsb_sideband_regs_test
  import dsb_pkg::*;
;
  localparam logic [15:0] IFW = 16'h00C4;
  localparam logic [15:0] TLV = 16'h0312;
  localparam logic [1:0]  OK  = `DSB_RESP_OKAY;
  localparam dsb_word_t   OP  = 32'h05D6_AA5C;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic        arready, rvalid, ddr4_mode, phy_cal_success, phy_cal_fail, cmd_ready, cmd_done;
  logic        cmd_valid, cmd_act, cmd_addr_hi, cmd_ras_n, cmd_cas_n, cmd_we_n, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, stacked_refresh_acknowledge_in;
  logic [3:0]  wstrb, cmd_cs;
  logic [1:0]  bresp, rresp, cmd_bank_group;
  logic [2:0]  refresh_chip_id, cmd_chip_id, cmd_bank;
  logic [13:0] cmd_addr;
  int          failures, checks_done;

  dsb_sideband_regs #(.IF_WIDTH_VALUE(IFW), .TOOL_VERSION_VALUE(TLV)) dsb_sideband_regs_i (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .ddr4_mode(ddr4_mode),
    .phy_cal_success(phy_cal_success), .phy_cal_fail(phy_cal_fail), .refresh_chip_id(refresh_chip_id),
    .stacked_refresh_acknowledge_in(stacked_refresh_acknowledge_in), .cmd_ready(cmd_ready),
    .cmd_done(cmd_done), .cmd_valid(cmd_valid), .cmd_cs(cmd_cs), .cmd_chip_id(cmd_chip_id),
    .cmd_act(cmd_act), .cmd_bank_group(cmd_bank_group), .cmd_bank(cmd_bank),
    .cmd_addr_hi(cmd_addr_hi), .cmd_ras_n(cmd_ras_n), .cmd_cas_n(cmd_cas_n), .cmd_we_n(cmd_we_n),
    .cmd_addr(cmd_addr), .irq(irq));

  always #10 aclk = ~aclk;

  task automatic complete_run();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input dsb_word_t exp, input dsb_word_t got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // No wait limit of its own: a lost answer is left to the watchdog
  task automatic wr(input dsb_idx_t idx, input dsb_word_t data, input logic [3:0] strb, input logic [1:0] er);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= data;
    wstrb <= strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk("bresp", {29'h0, 1'b1, er}, {29'h0, bvalid, bresp});
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input dsb_idx_t idx, output dsb_word_t d, output logic [2:0] r);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = {rvalid, rresp};
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rchk(input dsb_idx_t idx, input dsb_word_t exp, input string what);
    dsb_word_t  d;
    logic [2:0] r;
    rd(idx, d, r);
    chk(what, exp, d);
    chk("rresp", 32'h4, {29'h0, r});
  endtask

  task automatic t_reset_info();
    dsb_word_t  d;
    logic [2:0] r;
    rchk(`DSB_IDX_SELECT, 32'h0, "select");
    rchk(`DSB_IDX_OPERAND, 32'h0, "operand");
    rchk(`DSB_IDX_INPROG, 32'h0, "in_progress");
    chk("irq", 32'h0, {31'h0, irq});
    wr(`DSB_IDX_IFWIDTH, 32'hFFFF_FFFF, 4'hF, OK);
    wr(`DSB_IDX_TOOLVER, 32'hFFFF_FFFF, 4'hF, OK);
    rchk(`DSB_IDX_IFWIDTH, {16'h0, IFW}, "if_width");
    rchk(`DSB_IDX_TOOLVER, {16'h0, TLV}, "tool_version");
    rd(8'h50, d, r);
    chk("unmapped_resp", 32'h6, {29'h0, r});
    chk("unmapped_data", 32'h0, d);
    wr(8'h50, 32'h1, 4'hF, `DSB_RESP_SLVERR);
  endtask

  task automatic t_fields();
    wr(`DSB_IDX_SELECT, 32'hFFFF_FFFF, 4'hF, OK);
    rchk(`DSB_IDX_SELECT, 32'h7F, "select");
    wr(`DSB_IDX_OPERAND, 32'hA5A5_5A5A, 4'h3, OK);
    rchk(`DSB_IDX_OPERAND, 32'h0000_5A5A, "operand");
    wr(`DSB_IDX_OPERAND, 32'h1234_5678, 4'hC, OK);
    rchk(`DSB_IDX_OPERAND, 32'h1234_5A5A, "operand");
    rchk(`DSB_IDX_SELECT, 32'h7F, "select");
  endtask

  task automatic t_status();
    phy_cal_success <= 1'b1;
    refresh_chip_id <= 3'h5;
    stacked_refresh_acknowledge_in <= 32'h8040_2001;
    @(posedge aclk);
    rchk(`DSB_IDX_CALSTS, 32'h1, "cal_status");
    rchk(`DSB_IDX_CHIPID, 32'hA, "chip_id");
    wr(`DSB_IDX_REFACK, 32'h0, 4'hF, OK);
    rchk(`DSB_IDX_REFACK, 32'h8040_2001, "refresh_ack");
    phy_cal_success <= 1'b0;
    phy_cal_fail <= 1'b1;
    refresh_chip_id <= 3'h2;
    stacked_refresh_acknowledge_in <= 32'h0102_0408;
    @(posedge aclk);
    rchk(`DSB_IDX_CALSTS, 32'h2, "cal_status");
    rchk(`DSB_IDX_CHIPID, 32'h4, "chip_id");
    rchk(`DSB_IDX_REFACK, 32'h0102_0408, "refresh_ack");
    rchk(`DSB_IDX_IRQSTS, 32'h3, "irq_status");
    chk("irq", 32'h0, {31'h0, irq});
    wr(`DSB_IDX_IRQEN, 32'h2, 4'hF, OK);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`DSB_IDX_IRQCLR, 32'h3, 4'hF, OK);
    chk("irq", 32'h0, {31'h0, irq});
    wr(`DSB_IDX_IRQEN, 32'hF, 4'hF, OK);
  endtask

  // One full command: launch, refused relaunch, hand-off, completion
  task automatic t_cmd(input logic d4, input logic [3:0] rank, input dsb_word_t op);
    ddr4_mode <= d4;
    wr(`DSB_IDX_SELECT, {25'h0, rank, `DSB_KIND_MODE_REGISTER_SET}, 4'hF, OK);
    wr(`DSB_IDX_OPERAND, op, 4'hF, OK);
    wr(`DSB_IDX_LAUNCH, 32'h1, 4'hF, OK);
    chk("cmd_valid", 32'h1, {31'h0, cmd_valid});
    chk("cmd_cs", {28'h0, rank}, {28'h0, cmd_cs});
    chk("cmd_fields", d4 ? {5'h0, op[26:21], 1'b0, op[19:0]} : {11'h0, op[20:0]},
        {5'h0, cmd_chip_id, cmd_act, cmd_bank_group, cmd_bank, cmd_addr_hi, cmd_ras_n, cmd_cas_n, cmd_we_n, cmd_addr});
    rchk(`DSB_IDX_INPROG, 32'h1, "in_progress");
    wr(`DSB_IDX_LAUNCH, 32'h1, 4'hF, OK);
    rchk(`DSB_IDX_IRQSTS, 32'h8, "irq_status");
    wr(`DSB_IDX_IRQCLR, 32'h8, 4'hF, OK);
    cmd_ready <= 1'b1;
    @(posedge aclk);
    cmd_ready <= 1'b0;
    @(posedge aclk);
    chk("cmd_valid", 32'h0, {31'h0, cmd_valid});
    rchk(`DSB_IDX_INPROG, 32'h1, "in_progress");
    cmd_done <= 1'b1;
    @(posedge aclk);
    cmd_done <= 1'b0;
    @(posedge aclk);
    rchk(`DSB_IDX_INPROG, 32'h0, "in_progress");
    rchk(`DSB_IDX_IRQSTS, 32'h4, "irq_status");
    chk("irq", 32'h1, {31'h0, irq});
    wr(`DSB_IDX_IRQCLR, 32'h4, 4'hF, OK);
    chk("irq", 32'h0, {31'h0, irq});
  endtask

  // Reserved kinds 1 to 7, then an empty rank, must never reach the scheduler
  task automatic t_reject();
    for (int k = 1; k < 9; k++) begin
      wr(`DSB_IDX_SELECT, k < 8 ? {25'h0, 4'h1, k[2:0]} : 32'h0, 4'hF, OK);
      wr(`DSB_IDX_LAUNCH, 32'h1, 4'hF, OK);
      chk("cmd_valid", 32'h0, {31'h0, cmd_valid});
      rchk(`DSB_IDX_IRQSTS, 32'h8, "irq_status");
      wr(`DSB_IDX_IRQCLR, 32'h8, 4'hF, OK);
    end
  endtask

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, cmd_ready, cmd_done} = '0;
    {ddr4_mode, phy_cal_success, phy_cal_fail} = '0;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'h0;
    refresh_chip_id = 3'h0;
    stacked_refresh_acknowledge_in = 32'h0;
    failures = 0;
    checks_done = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset_info();
    t_fields();
    t_status();
    t_reject();
    t_cmd(1'b1, 4'h1, OP);
    t_cmd(1'b1, 4'h2, OP);
    t_cmd(1'b1, 4'h3, ~OP);
    t_cmd(1'b1, 4'hF, OP);
    t_cmd(1'b1, 4'h5, ~OP);
    t_cmd(1'b0, 4'h3, 32'hFFFF_FFFF);
    t_cmd(1'b0, 4'hA, OP);
    aresetn <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(`DSB_IDX_SELECT, 32'h0, "select");
    rchk(`DSB_IDX_OPERAND, 32'h0, "operand");
    complete_run();
  end

  // Whole run is well under a thousand cycles; this bound leaves wide margin
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    complete_run();
  end
endmodule
`default_nettype wire
